// ==== hdl/timer_oc_defines.vh ====
// Register offsets, field positions and reset values of the compare timer
`ifndef TIMER_OC_DEFINES_VH
`define TIMER_OC_DEFINES_VH

// ==========================================
// Register offsets (byte registers)
`define ADDR_CTRL_FIRST 4'h0
`define ADDR_CTRL_SECOND 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_CAP1_HI 4'h3
`define ADDR_CAP1_LO 4'h4
`define ADDR_CAP2_HI 4'h5
`define ADDR_CAP2_LO 4'h6
`define ADDR_CMP1_HI 4'h7
`define ADDR_CMP1_LO 4'h8
`define ADDR_CMP2_HI 4'h9
`define ADDR_CMP2_LO 4'ha
`define ADDR_COUNT_HI 4'hb
`define ADDR_COUNT_LO 4'hc

// ==========================================
// First control register fields
`define CF_CAPTURE_IRQ_EN 7
`define CF_COMPARE_IRQ_EN 6
`define CF_LEVEL_DURING_PULSE 2
`define CF_TRIGGER_EDGE 1
`define CF_LEVEL_AFTER_MATCH 0

// ==========================================
// Second control register fields
`define CS_PIN_EN_FIRST 7
`define CS_PIN_EN_SECOND 6
`define CS_SINGLE_PULSE 5
`define CS_PWM 4
`define CS_CLK_SEL_HI 3
`define CS_CLK_SEL_LO 2
`define CS_CAPTURE_EDGE_SECOND 1
`define CS_EXT_EDGE 0

// ==========================================
// Status register fields
`define ST_CAPTURE_FIRST 7
`define ST_COMPARE_FIRST 6
`define ST_CAPTURE_SECOND 4
`define ST_COMPARE_SECOND 3

// ==========================================
// Clock select codes
`define CLK_DIV4 2'h0
`define CLK_DIV2 2'h1
`define CLK_DIV8 2'h2
`define CLK_EXT 2'h3

// ==========================================
// Reset and preset values
`define CTRL_RESET 8'h00
`define COMPARE_RESET 16'h8000
`define COUNTER_RESET 16'h0000
`define CAPTURE_RESET 16'h0000
`define PULSE_COUNTER_PRESET 16'hfffc
`define PULSE_CAPTURE_VALUE 16'hfffd

`endif

// ==== hdl/pin_edge_sync.v ====
// Three-stage pin synchroniser with agreed-level edge detection
`timescale 1ns/1ps

module pin_edge_sync
(
	input wire clock,
	input wire sys_rst,
	input wire pin,
	output reg rise,
	output reg fall
);

reg stage1;
reg stage2;
reg stage3;
reg level;

// ==========================================
// Synchroniser and edge detect
// A change counts only once stages two and three agree
always @(posedge clock)
begin
	if (sys_rst)
	begin
		stage1 <= 1'b0;
		stage2 <= 1'b0;
		stage3 <= 1'b0;
		level <= 1'b0;
		rise <= 1'b0;
		fall <= 1'b0;
	end
	else
	begin
		stage1 <= pin;
		stage2 <= stage1;
		stage3 <= stage2;
		rise <= 1'b0;
		fall <= 1'b0;
		if ((stage2 == stage3) && (stage3 != level))
		begin
			level <= stage3;
			rise <= stage3;
			fall <= ~stage3;
		end
	end
end

endmodule

// ==== hdl/timer_output_compare_one_pulse.v ====
// Output compare and single-pulse section of a 16-bit free-running timer
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "timer_oc_defines.vh"

// What this block does
// [RQ1] Compare match drives programmed level to pin only when pin enabled
// [RQ2] Compare match sets that channel's compare flag in status
// [RQ3] Two 16-bit byte-split compare values checked each timer tick
// [RQ4] Compare values software read/write, hardware never changes them, reset 8000h
// [RQ5] Compare pin output latches forced low during reset
// [RQ6] Compare interrupt only when enabled and CPU mask clear
// [RQ7] Flag clears after status read with flag set, then low-byte access
// [RQ8] High-byte write inhibits compares until low-byte write, which clears flag once armed by a status read
// [RQ9] Single-pulse bit uses capture one trigger and compare one pulse
// [RQ10] Trigger polarity from trigger edge select; pin must be floating input
// [RQ11] Trigger presets counter FFFCh, pulse level out, capture flag, FFFDh
// [RQ12] Capture flag one from trigger raises interrupt if capture irq enabled
// [RQ13] Counter equal compare one ends pulse with after-pulse level
// [RQ14] Software programs compare one as duration times clock minus five
// [RQ15] Single-pulse never sets compare flag one; channel two still flags
// [RQ16] With PWM and single-pulse both set only PWM operates; no PWM mode is built, the PWM bit only disables single-pulse
// [RQ17] Single-pulse: pin one no capture, pin two captures, edges preset counter
// [RQ18] Single-pulse: compare two flags but drives no waveform
// [RQ19] Equal levels give constant pin one level through single pulse
// [RQ20] Clock select: 00 div4, 01 div2, 10 div8, 11 external
// [RQ21] External edge bit: 0 falling, 1 rising counts
// [RQ22] Counter increments per tick and wraps, unless trigger presets it
module timer_output_compare_one_pulse
#(
	parameter EXT_CLOCK_PRESENT = 1
)
(
	input wire clock,
	input wire sys_rst,
	input wire [3:0] address,
	input wire [7:0] write_data,
	input wire write_strobe,
	input wire read_strobe,
	output reg [7:0] read_data,
	input wire cpu_interrupt_mask,
	output wire timer_irq,
	input wire trigger_input_pin,
	input wire capture_input_pin_second,
	input wire external_clock_pin,
	output wire compare_output_pin_first,
	output wire compare_output_oe_first,
	output wire compare_output_pin_second,
	output wire compare_output_oe_second
);

reg [7:0] timer_control_first;
reg [7:0] timer_control_second;
reg [15:0] counter;
reg [31:0] compare_values;
reg [1:0] compare_match_flag;
reg [1:0] compare_clear_armed;
reg [1:0] compare_inhibit;
reg [1:0] compare_latch;
reg [15:0] capture_value_first;
reg [15:0] capture_value_second;
reg capture_flag_first;
reg capture_flag_second;
reg capture_armed_first;
reg capture_armed_second;
reg [2:0] prescale_factor;
reg tick;
reg [7:0] next_read_data;

wire trig_rise;
wire trig_fall;
wire cap2_rise;
wire cap2_fall;
wire ext_rise;
wire ext_fall;

wire [1:0] timer_clock_select;
wire external_clock_edge;
wire compare_irq_enable;
wire capture_irq_enable;
wire single_pulse_select;
wire single_pulse;
wire trigger_edge;
wire capture_edge_second;
wire status_read;

assign timer_clock_select = timer_control_second[`CS_CLK_SEL_HI:`CS_CLK_SEL_LO];
assign external_clock_edge = timer_control_second[`CS_EXT_EDGE];
assign compare_irq_enable = timer_control_first[`CF_COMPARE_IRQ_EN];
assign capture_irq_enable = timer_control_first[`CF_CAPTURE_IRQ_EN];
assign single_pulse_select = timer_control_second[`CS_SINGLE_PULSE];
// [RQ9] [RQ16] Pulse select, PWM overrides
assign single_pulse = single_pulse_select & ~timer_control_second[`CS_PWM];
// [RQ10] Trigger polarity select
assign trigger_edge = timer_control_first[`CF_TRIGGER_EDGE] ? trig_rise : trig_fall;
assign capture_edge_second = timer_control_second[`CS_CAPTURE_EDGE_SECOND] ?
	cap2_rise : cap2_fall;
assign status_read = read_strobe && (address == `ADDR_STATUS);

// ==========================================
// Pin synchronisers
pin_edge_sync trigger_sync
(
	.clock(clock),
	.sys_rst(sys_rst),
	.pin(trigger_input_pin),
	.rise(trig_rise),
	.fall(trig_fall)
);

pin_edge_sync capture_second_sync
(
	.clock(clock),
	.sys_rst(sys_rst),
	.pin(capture_input_pin_second),
	.rise(cap2_rise),
	.fall(cap2_fall)
);

pin_edge_sync ext_clock_sync
(
	.clock(clock),
	.sys_rst(sys_rst),
	.pin(external_clock_pin),
	.rise(ext_rise),
	.fall(ext_fall)
);

// ==========================================
// Timer clock enable
// Tick is registered, so it lags the prescaler by one cycle
always @(posedge clock)
begin
	if (sys_rst)
	begin
		prescale_factor <= 3'h0;
		tick <= 1'b0;
	end
	else
	begin
		prescale_factor <= prescale_factor + 3'h1;
		// [RQ20] Clock source select
		case (timer_clock_select)
			`CLK_DIV4: tick <= (prescale_factor[1:0] == 2'h3);
			`CLK_DIV2: tick <= prescale_factor[0];
			`CLK_DIV8: tick <= (prescale_factor == 3'h7);
			// [RQ21] External edge polarity
			default: tick <= (EXT_CLOCK_PRESENT != 0) &&
				(external_clock_edge ? ext_rise : ext_fall);
		endcase
	end
end

// ==========================================
// Free-running counter
always @(posedge clock)
begin
	if (sys_rst)
		counter <= `COUNTER_RESET;
	// [RQ11] Trigger presets counter
	else if (single_pulse && trigger_edge)
		counter <= `PULSE_COUNTER_PRESET;
	// [RQ22] Increment and wrap
	else if (tick)
		counter <= counter + 16'h0001;
end

// ==========================================
// Control registers
always @(posedge clock)
begin
	if (sys_rst)
	begin
		timer_control_first <= `CTRL_RESET;
		timer_control_second <= `CTRL_RESET;
	end
	else if (write_strobe)
	begin
		if (address == `ADDR_CTRL_FIRST)
			timer_control_first <= write_data;
		else if (address == `ADDR_CTRL_SECOND)
			timer_control_second <= write_data;
	end
end

// ==========================================
// Compare channels
genvar ch;
generate
	for (ch = 0; ch < 2; ch = ch + 1)
	begin : compare_channel
		localparam [3:0] HI_ADDR = (ch == 0) ? `ADDR_CMP1_HI : `ADDR_CMP2_HI;
		localparam [3:0] LO_ADDR = (ch == 0) ? `ADDR_CMP1_LO : `ADDR_CMP2_LO;
		localparam integer LEVEL_BIT = (ch == 0) ? `CF_LEVEL_AFTER_MATCH :
			`CF_LEVEL_DURING_PULSE;
		wire hi_write;
		wire lo_write;
		wire lo_access;
		wire match;
		wire flag_set;
		wire flag_clear;

		assign hi_write = write_strobe && (address == HI_ADDR);
		assign lo_write = write_strobe && (address == LO_ADDR);
		assign lo_access = lo_write || (read_strobe && (address == LO_ADDR));
		// [RQ3] Compare once per tick
		assign match = tick && !compare_inhibit[ch] &&
			(counter == compare_values[16*ch+15:16*ch]);
		// [RQ15] No flag one in single pulse
		assign flag_set = match && !(ch == 0 && single_pulse);
		// [RQ7] Clear after armed low access
		assign flag_clear = lo_access && compare_clear_armed[ch];

		// [RQ4] Software-only value
		always @(posedge clock)
		begin
			if (sys_rst)
				compare_values[16*ch+15:16*ch] <= `COMPARE_RESET;
			else if (hi_write)
				compare_values[16*ch+15:16*ch+8] <= write_data;
			else if (lo_write)
				compare_values[16*ch+7:16*ch] <= write_data;
		end

		always @(posedge clock)
		begin
			if (sys_rst)
			begin
				compare_match_flag[ch] <= 1'b0;
				compare_clear_armed[ch] <= 1'b0;
				compare_inhibit[ch] <= 1'b0;
			end
			else
			begin
				// [RQ2] Set wins over clear
				compare_match_flag[ch] <= flag_set ||
					(compare_match_flag[ch] && !flag_clear);
				if (status_read)
					compare_clear_armed[ch] <= compare_match_flag[ch];
				else if (lo_access)
					compare_clear_armed[ch] <= 1'b0;
				// [RQ8] Inhibit between high and low writes
				if (hi_write)
					compare_inhibit[ch] <= 1'b1;
				else if (lo_write)
					compare_inhibit[ch] <= 1'b0;
			end
		end

		always @(posedge clock)
		begin
			// [RQ5] Latch low in reset
			if (sys_rst)
				compare_latch[ch] <= 1'b0;
			else if (ch == 0 && single_pulse)
			begin
				// [RQ11] [RQ19] Pulse starts on trigger
				if (trigger_edge)
					compare_latch[ch] <= timer_control_first[`CF_LEVEL_DURING_PULSE];
				// [RQ13] Pulse ends on match
				else if (match)
					compare_latch[ch] <= timer_control_first[`CF_LEVEL_AFTER_MATCH];
			end
			// [RQ18] Channel two waveform held
			else if (ch == 1 && single_pulse)
				compare_latch[ch] <= compare_latch[ch];
			else if (match)
				compare_latch[ch] <= timer_control_first[LEVEL_BIT];
		end
	end
endgenerate

// [RQ1] Pin driven only when enabled
assign compare_output_pin_first = compare_latch[0];
assign compare_output_oe_first = timer_control_second[`CS_PIN_EN_FIRST];
assign compare_output_pin_second = compare_latch[1];
assign compare_output_oe_second = timer_control_second[`CS_PIN_EN_SECOND];

// ==========================================
// Capture channels
always @(posedge clock)
begin
	if (sys_rst)
	begin
		capture_value_first <= `CAPTURE_RESET;
		capture_value_second <= `CAPTURE_RESET;
		capture_flag_first <= 1'b0;
		capture_flag_second <= 1'b0;
		capture_armed_first <= 1'b0;
		capture_armed_second <= 1'b0;
	end
	else
	begin
		// [RQ17] Pin one trigger only in single pulse
		if (single_pulse && trigger_edge)
		begin
			// [RQ11] Fixed capture value and flag
			capture_value_first <= `PULSE_CAPTURE_VALUE;
			capture_flag_first <= 1'b1;
		end
		else if (!single_pulse && trigger_edge)
		begin
			capture_value_first <= counter;
			capture_flag_first <= 1'b1;
		end
		else if (capture_armed_first && read_strobe && (address == `ADDR_CAP1_LO))
			capture_flag_first <= 1'b0;
		// [RQ17] Pin two still captures
		if (capture_edge_second)
		begin
			capture_value_second <= counter;
			capture_flag_second <= 1'b1;
		end
		else if (capture_armed_second && read_strobe && (address == `ADDR_CAP2_LO))
			capture_flag_second <= 1'b0;
		if (status_read)
		begin
			capture_armed_first <= capture_flag_first;
			capture_armed_second <= capture_flag_second;
		end
		else if (read_strobe && (address == `ADDR_CAP1_LO))
			capture_armed_first <= 1'b0;
		else if (read_strobe && (address == `ADDR_CAP2_LO))
			capture_armed_second <= 1'b0;
	end
end

// ==========================================
// Interrupt request
// [RQ6] Compare interrupt gated by CPU mask
// [RQ12] Capture interrupt
assign timer_irq = !cpu_interrupt_mask &&
	((compare_irq_enable && (compare_match_flag != 2'h0)) ||
	(capture_irq_enable && (capture_flag_first || capture_flag_second)));

// ==========================================
// Read path
always @*
begin
	next_read_data = 8'h00;
	if (address == `ADDR_CTRL_FIRST)
		next_read_data = timer_control_first;
	else if (address == `ADDR_CTRL_SECOND)
		next_read_data = timer_control_second;
	else if (address == `ADDR_STATUS)
	begin
		next_read_data[`ST_CAPTURE_FIRST] = capture_flag_first;
		next_read_data[`ST_COMPARE_FIRST] = compare_match_flag[0];
		next_read_data[`ST_CAPTURE_SECOND] = capture_flag_second;
		next_read_data[`ST_COMPARE_SECOND] = compare_match_flag[1];
	end
	else if (address == `ADDR_CAP1_HI)
		next_read_data = capture_value_first[15:8];
	else if (address == `ADDR_CAP1_LO)
		next_read_data = capture_value_first[7:0];
	else if (address == `ADDR_CAP2_HI)
		next_read_data = capture_value_second[15:8];
	else if (address == `ADDR_CAP2_LO)
		next_read_data = capture_value_second[7:0];
	else if (address == `ADDR_CMP1_HI)
		next_read_data = compare_values[15:8];
	else if (address == `ADDR_CMP1_LO)
		next_read_data = compare_values[7:0];
	else if (address == `ADDR_CMP2_HI)
		next_read_data = compare_values[31:24];
	else if (address == `ADDR_CMP2_LO)
		next_read_data = compare_values[23:16];
	else if (address == `ADDR_COUNT_HI)
		next_read_data = counter[15:8];
	else if (address == `ADDR_COUNT_LO)
		next_read_data = counter[7:0];
end

// Data hold until the next read; only the cycle after the strobe is promised
always @(posedge clock)
begin
	if (sys_rst)
		read_data <= 8'h00;
	else if (read_strobe)
		read_data <= next_read_data;
end

endmodule

// ==== verif/timer_oc_checker.sv ====
// Port-level assertions for the compare timer
`timescale 1ns/1ps
`include "timer_oc_defines.vh"

module timer_oc_checker
(
	input wire clock,
	input wire sys_rst,
	input wire [3:0] address,
	input wire [7:0] write_data,
	input wire write_strobe,
	input wire read_strobe,
	input wire [7:0] read_data,
	input wire cpu_interrupt_mask,
	input wire timer_irq,
	input wire compare_output_pin_first,
	input wire compare_output_oe_first,
	input wire compare_output_pin_second,
	input wire compare_output_oe_second
);
	// ==========
	// Shadow of software-written registers
	logic [7:0] shadow [0:15];
	wire rw_addr = address < 4'h2 || (address > 4'h6 && address < 4'hb);
	wire [7:0] shadow_sel = shadow[address];
	wire [7:0] ctrl_a = shadow[`ADDR_CTRL_FIRST];
	wire [7:0] ctrl_b = shadow[`ADDR_CTRL_SECOND];
	wire pulse_mode = ctrl_b[`CS_SINGLE_PULSE] && !ctrl_b[`CS_PWM];

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < 16; i++)
				shadow[i] <= (i == 7 || i == 9) ? 8'h80 : 8'h00;
		end
		else if (write_strobe && rw_addr)
			shadow[address] <= write_data;
	end

	// ==========
	// Properties
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence s_ctrl_write;
		write_strobe && address == `ADDR_CTRL_SECOND;
	endsequence
	sequence s_reg_read;
		read_strobe && rw_addr;
	endsequence

	property p_latch_reset;
		disable iff (1'b0) sys_rst |=> !compare_output_pin_first && !compare_output_pin_second;
	endproperty
	property p_oe_follow;
		s_ctrl_write |=> {compare_output_oe_first, compare_output_oe_second} == $past(write_data[7:6]);
	endproperty
	property p_oe_hold;
		!$past(sys_rst) && !$past(write_strobe && address == `ADDR_CTRL_SECOND)
			|-> $stable({compare_output_oe_first, compare_output_oe_second});
	endproperty
	property p_reg_read;
		s_reg_read |=> read_data == $past(shadow_sel);
	endproperty
	property p_unmapped;
		read_strobe && address > `ADDR_COUNT_LO |=> read_data == 8'h00;
	endproperty
	property p_irq_gate;
		timer_irq |-> !cpu_interrupt_mask && (ctrl_a[7] || ctrl_a[6]);
	endproperty
	property p_pin2_frozen;
		pulse_mode |=> $stable(compare_output_pin_second);
	endproperty
	property p_steady;
		pulse_mode && ctrl_a[0] == ctrl_a[2] && compare_output_pin_first == ctrl_a[0]
			|=> compare_output_pin_first == $past(ctrl_a[0]);
	endproperty

	a_latch_reset: assert property (p_latch_reset) else $error("pin latch not low");
	a_oe_follow: assert property (p_oe_follow) else $error("enable differs");
	a_oe_hold: assert property (p_oe_hold) else $error("enable moved");
	a_reg_read: assert property (p_reg_read) else $error("register readback");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
	a_pin2_frozen: assert property (p_pin2_frozen) else $error("pin two moved");
	a_steady: assert property (p_steady) else $error("pin one not steady");
endmodule

bind timer_output_compare_one_pulse timer_oc_checker chk_u
(
	.clock(clock),
	.sys_rst(sys_rst),
	.address(address),
	.write_data(write_data),
	.write_strobe(write_strobe),
	.read_strobe(read_strobe),
	.read_data(read_data),
	.cpu_interrupt_mask(cpu_interrupt_mask),
	.timer_irq(timer_irq),
	.compare_output_pin_first(compare_output_pin_first),
	.compare_output_oe_first(compare_output_oe_first),
	.compare_output_pin_second(compare_output_pin_second),
	.compare_output_oe_second(compare_output_oe_second)
);

// ==== verif/pin_source_model.sv ====
// Far-side pin model: trigger, second capture and external clock
`timescale 1ns/1ps

module pin_source_model
(
	input wire clock,
	output logic trigger_input_pin,
	output logic capture_input_pin_second,
	output logic external_clock_pin
);
	initial
	begin
		trigger_input_pin = 1'b0;
		capture_input_pin_second = 1'b0;
		external_clock_pin = 1'b0;
	end

	task automatic toggles(input int which, input int n);
		repeat (n)
		begin
			@(posedge clock);
			case (which)
				0: trigger_input_pin <= ~trigger_input_pin;
				1: capture_input_pin_second <= ~capture_input_pin_second;
				default: external_clock_pin <= ~external_clock_pin;
			endcase
			repeat (8) @(posedge clock);
		end
	endtask
endmodule

// ==== verif/timer_output_compare_one_pulse_test.sv ====
// Self-checking bench for the compare timer
`timescale 1ns/1ps
`include "timer_oc_defines.vh"

module timer_output_compare_one_pulse_test;
	logic clock, sys_rst, write_strobe, read_strobe, cpu_interrupt_mask;
	logic [3:0] address;
	logic [7:0] write_data, rd_val, v;
	wire [7:0] read_data;
	wire timer_irq, trigger_input_pin, capture_input_pin_second, external_clock_pin;
	wire compare_output_pin_first, compare_output_oe_first;
	wire compare_output_pin_second, compare_output_oe_second;
	wire pin1 = compare_output_pin_first;
	wire pin2 = compare_output_pin_second;
	int n_fail, checks_done, lo_cycles;

	timer_output_compare_one_pulse dut_u
	(
		.clock(clock),
		.sys_rst(sys_rst),
		.address(address),
		.write_data(write_data),
		.write_strobe(write_strobe),
		.read_strobe(read_strobe),
		.read_data(read_data),
		.cpu_interrupt_mask(cpu_interrupt_mask),
		.timer_irq(timer_irq),
		.trigger_input_pin(trigger_input_pin),
		.capture_input_pin_second(capture_input_pin_second),
		.external_clock_pin(external_clock_pin),
		.compare_output_pin_first(compare_output_pin_first),
		.compare_output_oe_first(compare_output_oe_first),
		.compare_output_pin_second(compare_output_pin_second),
		.compare_output_oe_second(compare_output_oe_second)
	);
	pin_source_model pins_u
	(
		.clock(clock),
		.trigger_input_pin(trigger_input_pin),
		.capture_input_pin_second(capture_input_pin_second),
		.external_clock_pin(external_clock_pin)
	);

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	always @(posedge clock)
		if (!pin1)
			lo_cycles++;

	// ==========
	// Bus and compare helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
		// Let the written state settle before callers look
		@(negedge clock);
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		@(negedge clock);
		rd_val = read_data;
	endtask

	task automatic wait_pin(input logic which, input logic lvl);
		int cyc;
		cyc = 0;
		while ((which ? pin2 : pin1) !== lvl && cyc < 3000)
		begin
			@(posedge clock);
			cyc++;
		end
		check(cyc < 3000, 1'b1);
	endtask

	// Match one counter page ahead
	task automatic arm(input logic [3:0] hi);
		rd(`ADDR_COUNT_HI);
		wr(hi, rd_val + 8'h01);
		wr(hi + 4'h1, 8'h00);
	endtask

	// ==========
	// Scenarios
	task automatic t_reset();
		for (int a = 0; a < 16; a++)
		begin
			rd(a[3:0]);
			// Counter runs at divide by four from reset; low byte is 6 here
			check(rd_val, (a == 7 || a == 9) ? 8'h80 : (a == 12) ? 8'h06 : 8'h00);
		end
		check({pin1, pin2, compare_output_oe_first}, 3'b000);
	endtask

	task automatic t_match();
		wr(`ADDR_CTRL_FIRST, 8'h45);
		wr(`ADDR_CTRL_SECOND, 8'hc0);
		check({compare_output_oe_first, compare_output_oe_second}, 2'b11);
		arm(`ADDR_CMP1_HI);
		wait_pin(0, 1'b1);
		wr(`ADDR_CMP1_LO, 8'h00);
		rd(`ADDR_STATUS);
		check({rd_val[6], timer_irq}, 2'b11);
		@(posedge clock);
		cpu_interrupt_mask <= 1'b1;
		@(negedge clock);
		check(timer_irq, 1'b0);
		@(posedge clock);
		cpu_interrupt_mask <= 1'b0;
		wr(`ADDR_CMP1_LO, 8'h00);
		rd(`ADDR_STATUS);
		check(rd_val[6], 1'b0);
	endtask

	task automatic t_inhibit();
		rd(`ADDR_COUNT_HI);
		wr(`ADDR_CMP2_HI, rd_val + 8'h02);
		repeat (2200) @(posedge clock);
		rd(`ADDR_STATUS);
		check({rd_val[3], pin2}, 2'b00);
		arm(`ADDR_CMP2_HI);
		wait_pin(1, 1'b1);
		rd(`ADDR_STATUS);
		check(rd_val[3], 1'b1);
	endtask

	task automatic t_clock();
		int rate [0:2] = '{16, 32, 8};
		for (int c = 0; c < 5; c++)
		begin
			if (c < 3)
				wr(`ADDR_CTRL_SECOND, {4'h0, c[1:0], 2'h0});
			else
				wr(`ADDR_CTRL_SECOND, {4'h0, `CLK_EXT, 1'b0, c[0]});
			repeat (8) @(posedge clock);
			rd(`ADDR_COUNT_LO);
			v = rd_val;
			if (c < 3)
				repeat (62) @(posedge clock);
			else
				pins_u.toggles(2, 20);
			rd(`ADDR_COUNT_LO);
			// Low byte may wrap inside the window
			check(8'(rd_val - v), (c < 3) ? rate[c] : 10);
		end
	endtask

	task automatic t_pulse();
		wr(`ADDR_CMP1_HI, 8'h00);
		wr(`ADDR_CMP1_LO, 8'h10);
		wr(`ADDR_CTRL_FIRST, 8'h83);
		wr(`ADDR_CTRL_SECOND, 8'ha2);
		check({pin1, timer_irq}, 2'b10);
		lo_cycles = 0;
		pins_u.toggles(0, 1);
		check({pin1, timer_irq}, 2'b01);
		rd(`ADDR_COUNT_HI);
		check(rd_val, 8'hff);
		rd(`ADDR_CAP1_HI);
		v = rd_val;
		rd(`ADDR_CAP1_LO);
		check({v, rd_val}, 16'hfffd);
		pins_u.toggles(1, 1);
		wait_pin(0, 1'b1);
		check(lo_cycles >= 80 && lo_cycles <= 87, 1'b1);
		rd(`ADDR_STATUS);
		check({rd_val[7:6], rd_val[4]}, 3'b101);
		wr(`ADDR_CTRL_SECOND, 8'hb0);
		pins_u.toggles(0, 2);
		check(pin1, 1'b1);
		wr(`ADDR_CTRL_FIRST, 8'h87);
		wr(`ADDR_CTRL_SECOND, 8'ha0);
		pins_u.toggles(0, 2);
		check(pin1, 1'b1);
	endtask

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		sys_rst = 1'b1;
		{write_strobe, read_strobe, cpu_interrupt_mask} = 3'b000;
		address = 4'h0;
		write_data = 8'h00;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_match();
		t_inhibit();
		t_clock();
		t_pulse();
		stop_test();
	end

	// Run is well under ten thousand cycles
	initial
	begin
		repeat (20000) @(posedge clock);
		n_fail++;
		$display("unexpected at %0t: run hung", $time);
		stop_test();
	end
endmodule
